//--- rtl/enc_mbox_pkg.sv
// Shared constants and types for the encoder register mailbox block
package enc_mbox_pkg;
	localparam logic [7:0] ADDR_HW_ID = 8'h84;
	localparam logic [7:0] ADDR_SWITCH = 8'h85;
	localparam logic [7:0] ADDR_SPD_DST1 = 8'h86;
	localparam logic [7:0] ADDR_SPD_DST2 = 8'h87;
	localparam logic [7:0] ADDR_MBOX = 8'h88;
	localparam logic [7:0] ADDR_CNT1 = 8'h8c;
	localparam logic [7:0] ADDR_CNT2 = 8'h90;
	localparam logic [7:0] ADDR_DEST1 = 8'h94;
	localparam logic [7:0] ADDR_DEST2 = 8'h98;
	localparam logic [7:0] ADDR_DIST1 = 8'h9c;
	localparam logic [7:0] ADDR_DIST2 = 8'h9d;
	localparam logic [7:0] ADDR_SPEED1 = 8'h9e;
	localparam logic [7:0] ADDR_SPEED2 = 8'h9f;
	localparam logic [7:0] ADDR_TBASE1 = 8'ha2;
	localparam logic [7:0] ADDR_TBASE2 = 8'ha3;
	localparam logic [7:0] ADDR_THRESH = 8'ha4;
	localparam logic [7:0] ADDR_DIVIDER = 8'ha5;
	localparam logic [7:0] ADDR_MODE = 8'ha6;
	// Fixed 2.5 V of 5 V full scale: 255 * 2.5 / 5, rounded
	localparam logic [7:0] THRESH_FIXED = 8'h80;
	localparam logic [7:0] TBASE_RESET = 8'h10;
	localparam logic [7:0] DIVIDER_RESET = 8'h01;
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam int MODE_DIST_BIT = 0;
	localparam logic signed [7:0] REL_MAX = 8'sh7f;
	localparam logic signed [7:0] REL_MIN = -8'sh7f;
	localparam logic [7:0] REPLY_OK = 8'h2b;
	localparam logic [7:0] REPLY_ERR = 8'h2d;
	typedef enum logic [2:0] {
		CMD_RD_BYTE,
		CMD_WR_BYTE,
		CMD_MBOX_TO_REG,
		CMD_REG_TO_MBOX,
		CMD_HEX_OUT
	} cmd_e;
	// Transfer selector: 0,1 counters; 2,3 destinations
	localparam logic [1:0] SEL_CNT1 = 2'd0;
	localparam logic [1:0] SEL_CNT2 = 2'd1;
	localparam logic [1:0] SEL_DEST1 = 2'd2;
	localparam logic [1:0] SEL_DEST2 = 2'd3;
	// Host register offsets (Avalon word addresses, byte address = 4*index)
	localparam logic [3:0] HREG_CMD = 4'h0;
	localparam logic [3:0] HREG_STATUS = 4'h1;
	localparam logic [3:0] HREG_RDATA = 4'h2;
	localparam logic [3:0] HREG_HEX_LO = 4'h3;
	localparam logic [3:0] HREG_HEX_HI = 4'h4;
	localparam int HCMD_OP_LSB = 16;
	localparam int HCMD_ADDR_LSB = 8;
endpackage : enc_mbox_pkg

//--- rtl/enc_mbox_if.sv
// Byte command link between the host controller and the encoder module
`timescale 1ns/1ps
interface enc_mbox_if;
	import enc_mbox_pkg::*;
	logic req;
	cmd_e cmd;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic ack;
	logic [7:0] rdata;
	logic [3:0] hex_len;
	logic [31:0] hex_digits;
	modport device (input req, input cmd, input addr, input wdata,
		output ack, output rdata, output hex_len, output hex_digits);
	modport host (output req, output cmd, output addr, output wdata,
		input ack, input rdata, input hex_len, input hex_digits);
endinterface : enc_mbox_if

//--- rtl/enc_mbox_device.sv
// Encoder module end: registers, mailbox, counters and hex compression
//
// Overview of operation
// - Report 4-bit hardware and jumper identity
// - Switch states in low four bits
// - Mode register picks speed or distance
// - 32-bit counters, byte-wide register accesses
// - Host fills mailbox before transfer command
// - Mailbox copied into target in one step
// - Read command snapshots target into mailbox
// - Same mailbox path serves destination registers
// - Host avoids direct counter byte access
// - Destinations hold targets, loaded via mailbox
// - Distance is signed, clamped to +-127
// - Speed is signed 8-bit relative value
// - Overspeed saturates at full scale, signed
// - Two time bases, divider, threshold parameters
// - Threshold fixed at 2.5 V here
// - Drop leading 0 or F digits
// - Positive string starting 8..F gets 0
// - Negative string starting 0..7 gets F
// - Receiver pads back to eight digits
// - Host writes only documented parameters
// - Mailbox at 88h, most significant first
// - Parameter write answers plus or minus
`timescale 1ns/1ps
module enc_mbox_device
	import enc_mbox_pkg::*;
#(
	parameter logic [1:0] HW_VERSION = 2'h1 // Arbitrary value
) (
	input wire logic MCLK,
	input wire logic RST_N,
	enc_mbox_if.device LINK,
	input wire logic [1:0] ENC_A,
	input wire logic [1:0] ENC_B,
	input wire logic [3:0] LIMIT_SW,
	input wire logic [1:0] JUMPER,
	input wire logic signed [15:0] SPEED_RAW [2],
	output logic [7:0] THRESHOLD_LEVEL,
	output logic [7:0] DIVIDER
);
	logic [1:0] a_s1_reg, a_s2_reg, b_s1_reg, b_s2_reg;
	logic [3:0] sw_s1_reg, sw_s2_reg;
	logic [1:0] jp_s1_reg, jp_s2_reg;
	logic [1:0] a_old_reg, b_old_reg;
	logic signed [31:0] cnt_reg [2];
	logic signed [31:0] cnt_next [2];
	logic signed [31:0] dest_reg [2];
	logic signed [31:0] dest_next [2];
	logic [31:0] mbox_reg, mbox_next;
	logic [7:0] tbase_reg [2];
	logic [7:0] tbase_next [2];
	logic [7:0] div_reg, div_next, mode_reg, mode_next;
	logic signed [7:0] dist_reg [2];
	logic signed [7:0] speed_reg [2];
	logic ack_reg, ack_next;
	logic [7:0] rdata_reg, rdata_next;
	logic [3:0] hlen_reg, hlen_next;
	logic [31:0] hdig_reg, hdig_next;

	// Clamp a wide signed value into -127..+127
	function automatic logic signed [7:0] sat8(input logic signed [31:0] v);
		if (v > 32'sd127)
			return REL_MAX;
		else if (v < -32'sd127)
			return REL_MIN;
		else
			return v[7:0];
	endfunction : sat8

	// Which 32-bit register a byte address falls in; zero outside them
	function automatic logic [31:0] wide_of(input logic [7:0] a);
		logic [31:0] w;
		w = 32'h0;
		if (a >= ADDR_MBOX && a < ADDR_CNT1)
			w = mbox_reg;
		else if (a >= ADDR_CNT1 && a < ADDR_CNT2)
			w = cnt_reg[0];
		else if (a >= ADDR_CNT2 && a < ADDR_DEST1)
			w = cnt_reg[1];
		else if (a >= ADDR_DEST1 && a < ADDR_DEST2)
			w = dest_reg[0];
		else if (a >= ADDR_DEST2 && a < ADDR_DIST1)
			w = dest_reg[1];
		return w;
	endfunction : wide_of

	// Fewest digits whose top digit still carries the sign
	function automatic logic [3:0] hex_len_of(input logic [31:0] v);
		logic [3:0] n;
		n = 4'h8;
		for (int k = 7; k >= 1; k--)
			if (32'($signed(v << (32 - 4 * k)) >>> (32 - 4 * k)) == v)
				n = 4'(k);
		return n;
	endfunction : hex_len_of

	function automatic logic [7:0] lane(input logic [31:0] w,
		input logic [1:0] i);
		// Lowest address carries bits 31:24
		return w[8*(3-i) +: 8];
	endfunction : lane

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			a_s1_reg <= 2'h0;
			a_s2_reg <= 2'h0;
			b_s1_reg <= 2'h0;
			b_s2_reg <= 2'h0;
			sw_s1_reg <= 4'h0;
			sw_s2_reg <= 4'h0;
			jp_s1_reg <= 2'h0;
			jp_s2_reg <= 2'h0;
			a_old_reg <= 2'h0;
			b_old_reg <= 2'h0;
		end else begin
			a_s1_reg <= ENC_A;
			a_s2_reg <= a_s1_reg;
			b_s1_reg <= ENC_B;
			b_s2_reg <= b_s1_reg;
			sw_s1_reg <= LIMIT_SW;
			sw_s2_reg <= sw_s1_reg;
			jp_s1_reg <= JUMPER;
			jp_s2_reg <= jp_s1_reg;
			a_old_reg <= a_s2_reg;
			b_old_reg <= b_s2_reg;
		end
	end

	always_comb begin
		logic [7:0] ofs;
		logic [31:0] sel_val;
		ofs = LINK.addr;
		sel_val = ofs[1] ? dest_reg[ofs[0]] : cnt_reg[ofs[0]];
		cnt_next = cnt_reg;
		dest_next = dest_reg;
		mbox_next = mbox_reg;
		tbase_next = tbase_reg;
		div_next = div_reg;
		mode_next = mode_reg;
		ack_next = 1'b0;
		rdata_next = rdata_reg;
		hlen_next = hlen_reg;
		hdig_next = hdig_reg;
		for (int i = 0; i < 2; i++) begin
			// One step per quadrature edge, sign from the phase relation
			if ((a_s2_reg[i] ^ a_old_reg[i]) || (b_s2_reg[i] ^ b_old_reg[i]))
			begin
				if (a_s2_reg[i] ^ b_old_reg[i])
					cnt_next[i] = cnt_reg[i] + 32'sd1;
				else
					cnt_next[i] = cnt_reg[i] - 32'sd1;
			end
		end
		if (LINK.req && !ack_reg) begin
			ack_next = 1'b1;
			unique case (LINK.cmd)
			CMD_RD_BYTE: begin
				if (ofs == ADDR_HW_ID)
					rdata_next = {4'h0, HW_VERSION, jp_s2_reg};
				else if (ofs == ADDR_SWITCH)
					rdata_next = {4'h0, sw_s2_reg};
				else if (ofs == ADDR_SPD_DST1 || ofs == ADDR_SPD_DST2)
					rdata_next = mode_reg[MODE_DIST_BIT] ?
						dist_reg[ofs[0]] : speed_reg[ofs[0]];
				else if (ofs == ADDR_DIST1 || ofs == ADDR_DIST2)
					rdata_next = dist_reg[ofs[0]];
				else if (ofs == ADDR_SPEED1 || ofs == ADDR_SPEED2)
					rdata_next = speed_reg[ofs[0]];
				else if (ofs == ADDR_TBASE1 || ofs == ADDR_TBASE2)
					rdata_next = tbase_reg[ofs[0]];
				else if (ofs == ADDR_THRESH)
					rdata_next = THRESH_FIXED;
				else if (ofs == ADDR_DIVIDER)
					rdata_next = div_reg;
				else if (ofs == ADDR_MODE)
					rdata_next = mode_reg;
				else
					rdata_next = lane(wide_of(ofs), ofs[1:0]);
			end
			CMD_WR_BYTE: begin
				rdata_next = REPLY_OK;
				if (ofs >= ADDR_MBOX && ofs < ADDR_CNT1)
					mbox_next[8*(3-ofs[1:0]) +: 8] = LINK.wdata;
				else if (ofs == ADDR_TBASE1 || ofs == ADDR_TBASE2)
					tbase_next[ofs[0]] = LINK.wdata;
				else if (ofs == ADDR_DIVIDER)
					div_next = LINK.wdata;
				else if (ofs == ADDR_MODE)
					mode_next = LINK.wdata;
				else if (ofs == ADDR_THRESH)
					rdata_next = REPLY_OK;
				else
					rdata_next = REPLY_ERR;
			end
			CMD_MBOX_TO_REG: begin
				if (ofs[1])
					dest_next[ofs[0]] = mbox_reg;
				else
					cnt_next[ofs[0]] = mbox_reg;
				rdata_next = REPLY_OK;
			end
			CMD_REG_TO_MBOX: begin
				mbox_next = ofs[1] ? dest_reg[ofs[0]] : cnt_reg[ofs[0]];
				rdata_next = REPLY_OK;
			end
			CMD_HEX_OUT: begin
				mbox_next = sel_val;
				hlen_next = hex_len_of(sel_val);
				hdig_next = sel_val;
				rdata_next = REPLY_OK;
			end
			default: rdata_next = REPLY_ERR;
			endcase
		end
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			cnt_reg <= '{32'sh0, 32'sh0};
			dest_reg <= '{32'sh0, 32'sh0};
			mbox_reg <= 32'h0;
			tbase_reg <= '{TBASE_RESET, TBASE_RESET};
			div_reg <= DIVIDER_RESET;
			mode_reg <= MODE_RESET;
			ack_reg <= 1'b0;
			rdata_reg <= 8'h0;
			hlen_reg <= 4'h0;
			hdig_reg <= 32'h0;
			dist_reg <= '{8'sh0, 8'sh0};
			speed_reg <= '{8'sh0, 8'sh0};
			THRESHOLD_LEVEL <= THRESH_FIXED;
			DIVIDER <= DIVIDER_RESET;
		end else begin
			cnt_reg <= cnt_next;
			dest_reg <= dest_next;
			mbox_reg <= mbox_next;
			tbase_reg <= tbase_next;
			div_reg <= div_next;
			mode_reg <= mode_next;
			ack_reg <= ack_next;
			rdata_reg <= rdata_next;
			hlen_reg <= hlen_next;
			hdig_reg <= hdig_next;
			for (int i = 0; i < 2; i++) begin
				dist_reg[i] <= sat8(dest_reg[i] - cnt_reg[i]);
				speed_reg[i] <= sat8(32'(SPEED_RAW[i]));
			end
			THRESHOLD_LEVEL <= THRESH_FIXED;
			DIVIDER <= div_reg;
		end
	end

	assign LINK.ack = ack_reg;
	assign LINK.rdata = rdata_reg;
	assign LINK.hex_len = hlen_reg;
	assign LINK.hex_digits = hdig_reg;
endmodule : enc_mbox_device

//--- rtl/enc_mbox_host.sv
// Host controller end: Avalon-MM command registers driving the byte link
`timescale 1ns/1ps
module enc_mbox_host
	import enc_mbox_pkg::*;
(
	input wire logic MCLK,
	input wire logic RST_N,
	enc_mbox_if.host LINK,
	input wire logic [3:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST
);
	typedef enum {IDLE, WAIT_ACK, DONE} hstate_e;
	hstate_e st_reg, st_next;
	logic req_reg, req_next;
	cmd_e cmd_reg, cmd_next;
	logic [7:0] addr_reg, addr_next, wdata_reg, wdata_next;
	logic [7:0] rd_reg, rd_next;
	logic [31:0] hex_reg, hex_next;
	logic [3:0] len_reg, len_next;
	logic done_reg, done_next;
	logic [31:0] rdd_next;

	// Restore full eight digits from the shortened form
	function automatic logic [31:0] pad(input logic [31:0] d,
		input logic [3:0] n);
		logic [31:0] r;
		r = d;
		for (int k = 1; k < 8; k++)
			// No length yet after reset: leave the word as it is
			if (k >= n && n != 4'h0)
				r[4*k +: 4] = d[4*n-1] ? 4'hf : 4'h0;
		return r;
	endfunction : pad

	always_comb begin
		st_next = st_reg;
		req_next = req_reg;
		cmd_next = cmd_reg;
		addr_next = addr_reg;
		wdata_next = wdata_reg;
		rd_next = rd_reg;
		hex_next = hex_reg;
		len_next = len_reg;
		done_next = done_reg;
		rdd_next = 32'h0;
		unique case (st_reg)
		IDLE: begin
			if (AVS_WRITE && AVS_ADDRESS == HREG_CMD) begin
				// Software drives order: mailbox bytes first, then transfer
				cmd_next = cmd_e'(AVS_WRITEDATA[HCMD_OP_LSB +: 3]);
				addr_next = AVS_WRITEDATA[HCMD_ADDR_LSB +: 8];
				wdata_next = AVS_WRITEDATA[7:0];
				req_next = 1'b1;
				done_next = 1'b0;
				st_next = WAIT_ACK;
			end else if (AVS_READ) begin
				st_next = DONE;
				unique case (AVS_ADDRESS)
				HREG_STATUS: rdd_next = {31'h0, done_reg};
				HREG_RDATA: rdd_next = {24'h0, rd_reg};
				HREG_HEX_LO: rdd_next = hex_reg;
				HREG_HEX_HI: rdd_next = {28'h0, len_reg};
				default: rdd_next = 32'h0;
				endcase
			end else if (AVS_WRITE) begin
				st_next = DONE;
			end
		end
		WAIT_ACK: begin
			if (LINK.ack) begin
				req_next = 1'b0;
				rd_next = LINK.rdata;
				len_next = LINK.hex_len;
				hex_next = pad(LINK.hex_digits, LINK.hex_len);
				done_next = 1'b1;
				st_next = DONE;
			end
		end
		DONE: st_next = IDLE;
		endcase
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			st_reg <= IDLE;
			req_reg <= 1'b0;
			cmd_reg <= CMD_RD_BYTE;
			addr_reg <= 8'h0;
			wdata_reg <= 8'h0;
			rd_reg <= 8'h0;
			hex_reg <= 32'h0;
			len_reg <= 4'h0;
			done_reg <= 1'b0;
			AVS_READDATA <= 32'h0;
			AVS_WAITREQUEST <= 1'b1;
		end else begin
			st_reg <= st_next;
			req_reg <= req_next;
			cmd_reg <= cmd_next;
			addr_reg <= addr_next;
			wdata_reg <= wdata_next;
			rd_reg <= rd_next;
			hex_reg <= hex_next;
			len_reg <= len_next;
			done_reg <= done_next;
			if (st_reg == IDLE && AVS_READ)
				AVS_READDATA <= rdd_next;
			AVS_WAITREQUEST <= !(st_next == DONE);
		end
	end

	assign LINK.req = req_reg;
	assign LINK.cmd = cmd_reg;
	assign LINK.addr = addr_reg;
	assign LINK.wdata = wdata_reg;
endmodule : enc_mbox_host

//--- bench/enc_mbox_chk.sv
// Link handshake and hex compression checker
`timescale 1ns/1ps
module enc_mbox_chk
	import enc_mbox_pkg::*;
(
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic req,
	input wire cmd_e cmd,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic ack,
	input wire logic [7:0] rdata,
	input wire logic [3:0] hex_len,
	input wire logic [31:0] hex_digits
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_N);

	// Sign-extend the low n digits back to a full word
	function automatic logic [31:0] sx(input logic [31:0] v, input int n);
		logic [31:0] m;
		m = (n > 7) ? 32'hffffffff : (32'h1 << (4 * n)) - 32'h1;
		return v[4 * n - 1] ? (v | ~m) : (v & m);
	endfunction : sx

	sequence s_take;
		req && !ack;
	endsequence
	sequence s_hex;
		ack && cmd == CMD_HEX_OUT;
	endsequence

	a_ack_follows: assert property (s_take |=> ack)
		else $error("no acknowledge one cycle after request");
	a_ack_pulse: assert property (ack |=> !ack && !req)
		else $error("acknowledge longer than one cycle");
	a_no_stray: assert property (!req |=> !ack)
		else $error("acknowledge without request");
	a_req_hold: assert property (s_take |=> req && $stable(cmd) &&
		$stable(addr) && $stable(wdata))
		else $error("request changed before acknowledge");
	a_req_gap: assert property ($fell(req) |=> !req)
		else $error("requests too close");
	a_reply_hold: assert property (!ack |-> $stable(rdata) &&
		$stable(hex_len) && $stable(hex_digits))
		else $error("reply changed between commands");
	a_wr_reply: assert property (ack && cmd == CMD_WR_BYTE |->
		rdata == REPLY_OK || rdata == REPLY_ERR)
		else $error("write reply not plus or minus");
	a_bad_addr: assert property (ack && cmd == CMD_WR_BYTE &&
		addr == 8'h00 |-> rdata == REPLY_ERR)
		else $error("bad address write not refused");
	a_thr_fixed: assert property (ack && cmd == CMD_RD_BYTE &&
		addr == ADDR_THRESH |-> rdata == THRESH_FIXED)
		else $error("threshold not fixed");
	a_hex_len: assert property (s_hex |-> hex_len inside {[1:8]})
		else $error("hex length out of range");
	a_hex_sign: assert property (s_hex |->
		sx(hex_digits, int'(hex_len)) == hex_digits)
		else $error("hex string does not carry the sign");
	a_hex_short: assert property (s_hex ##0 hex_len > 4'h1 |->
		sx(hex_digits, int'(hex_len) - 1) != hex_digits)
		else $error("hex string not shortest");
	c_hex: cover property (s_hex ##0 hex_len > 4'h5);
endmodule : enc_mbox_chk

//--- bench/encoder_register_mailbox_tb.sv
// Bench: Avalon host registers through the link to the encoder end
`timescale 1ns/1ps
module encoder_register_mailbox_tb;
	import enc_mbox_pkg::*;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] av_addr = 4'h0;
	logic av_rd = 1'b0;
	logic av_wr = 1'b0;
	logic [31:0] av_wd = 32'h0;
	logic [31:0] av_rdata;
	logic av_wait;
	logic [1:0] enc_a = 2'h0;
	logic [1:0] enc_b = 2'h0;
	logic [3:0] limit = 4'ha;
	logic [1:0] jumper = 2'h2;
	logic signed [15:0] spd [2] = '{16'sd300, -16'sd20};
	logic [7:0] thr_lvl;
	logic [7:0] div;
	int n_fail = 0;
	int compares = 0;
	logic [31:0] q;
	logic [31:0] cv [4] = '{32'h12345678, 32'h9, 32'h80000000, 32'h5};
	logic [31:0] hv [6] = '{32'h5, 32'hfa, 32'hfffffffa, 32'hffffff15,
		32'h056cb872, 32'hff862455};
	logic [3:0] hl [6] = '{4'h1, 4'h3, 4'h1, 4'h3, 4'h7, 4'h6};

	always #2 mclk = ~mclk;

	enc_mbox_if u_enc_mbox_if();
	enc_mbox_host u_enc_mbox_host (.MCLK(mclk), .RST_N(rst_n),
		.LINK(u_enc_mbox_if), .AVS_ADDRESS(av_addr), .AVS_READ(av_rd),
		.AVS_WRITE(av_wr), .AVS_WRITEDATA(av_wd), .AVS_READDATA(av_rdata),
		.AVS_WAITREQUEST(av_wait));
	enc_mbox_device u_enc_mbox_device (.MCLK(mclk), .RST_N(rst_n),
		.LINK(u_enc_mbox_if), .ENC_A(enc_a), .ENC_B(enc_b),
		.LIMIT_SW(limit), .JUMPER(jumper), .SPEED_RAW(spd),
		.THRESHOLD_LEVEL(thr_lvl), .DIVIDER(div));
	enc_mbox_chk u_enc_mbox_chk (.MCLK(mclk), .RST_N(rst_n),
		.req(u_enc_mbox_if.req), .cmd(u_enc_mbox_if.cmd),
		.addr(u_enc_mbox_if.addr), .wdata(u_enc_mbox_if.wdata),
		.ack(u_enc_mbox_if.ack), .rdata(u_enc_mbox_if.rdata),
		.hex_len(u_enc_mbox_if.hex_len),
		.hex_digits(u_enc_mbox_if.hex_digits));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
		input string nm);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic complete_run;
		$display("compares %0d, mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : complete_run

	// One Avalon transfer, held until waitrequest is sampled low
	task automatic av(input logic w, input logic [3:0] a,
		input logic [31:0] d);
		int i;
		@(posedge mclk);
		av_addr <= a;
		av_wr <= w;
		av_rd <= !w;
		av_wd <= d;
		i = 0;
		do begin
			@(posedge mclk);
			i++;
		end while (av_wait !== 1'b0 && i < 200);
		q = av_rdata;
		av_wr <= 1'b0;
		av_rd <= 1'b0;
		if (i >= 200)
			chk(32'h0, 32'h1, "waitrequest");
	endtask : av

	task automatic cmd(input cmd_e op, input logic [7:0] a,
		input logic [7:0] d);
		av(1'b1, HREG_CMD, {13'h0, op, a, d});
	endtask : cmd

	task automatic rdb(input logic [7:0] a, input logic [7:0] e,
		input string nm);
		cmd(CMD_RD_BYTE, a, 8'h00);
		av(1'b0, HREG_RDATA, 32'h0);
		chk({24'h0, q[7:0]}, {24'h0, e}, nm);
	endtask : rdb

	task automatic wrb(input logic [7:0] a, input logic [7:0] d,
		input logic [7:0] e);
		cmd(CMD_WR_BYTE, a, d);
		av(1'b0, HREG_RDATA, 32'h0);
		chk({24'h0, q[7:0]}, {24'h0, e}, "reply");
	endtask : wrb

	task automatic mbox_wr(input logic [31:0] v);
		for (int i = 0; i < 4; i++)
			wrb(ADDR_MBOX + 8'(i), v[31 - 8 * i -: 8], REPLY_OK);
	endtask : mbox_wr

	task automatic mbox_chk(input logic [31:0] v);
		for (int i = 0; i < 4; i++)
			rdb(ADDR_MBOX + 8'(i), v[31 - 8 * i -: 8], "mailbox");
	endtask : mbox_chk

	initial begin
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		rdb(ADDR_TBASE1, TBASE_RESET, "tbase1");
		rdb(ADDR_TBASE2, TBASE_RESET, "tbase2");
		rdb(ADDR_DIVIDER, DIVIDER_RESET, "divider");
		rdb(ADDR_MODE, MODE_RESET, "mode");
		wrb(ADDR_THRESH, 8'h20, REPLY_OK);
		rdb(ADDR_THRESH, THRESH_FIXED, "threshold");
		chk({24'h0, thr_lvl}, {24'h0, THRESH_FIXED}, "thr pin");
		wrb(ADDR_DIVIDER, 8'h05, REPLY_OK);
		chk({24'h0, div}, 32'h5, "divider pin");
		wrb(8'h00, 8'h55, REPLY_ERR);
		wrb(ADDR_TBASE1, 8'h33, REPLY_OK);
		rdb(ADDR_TBASE1, 8'h33, "tbase1");
		av(1'b1, 4'hf, 32'hffffffff);
		av(1'b0, 4'hf, 32'h0);
		chk(q, 32'h0, "unmapped");
		$display("test parameters done");
		rdb(ADDR_SWITCH, 8'h0a, "switches");
		cmd(CMD_RD_BYTE, ADDR_HW_ID, 8'h00);
		av(1'b0, HREG_RDATA, 32'h0);
		chk({28'h0, q[7:4]}, 32'h0, "id width");
		chk({30'h0, q[1:0]}, {30'h0, jumper}, "id jumpers");
		$display("test status done");
		for (int s = 0; s < 4; s++) begin
			mbox_wr(cv[s]);
			cmd(CMD_MBOX_TO_REG, 8'(s), 8'h00);
			av(1'b0, HREG_STATUS, 32'h0);
			chk(q, 32'h1, "done flag");
		end
		mbox_wr(32'h0);
		for (int s = 0; s < 4; s++) begin
			cmd(CMD_REG_TO_MBOX, 8'(s), 8'h00);
			mbox_chk(cv[s]);
		end
		$display("test mailbox done");
		for (int k = 0; k < 6; k++) begin
			mbox_wr(hv[k]);
			cmd(CMD_MBOX_TO_REG, 8'(SEL_CNT1), 8'h00);
			cmd(CMD_HEX_OUT, 8'(SEL_CNT1), 8'h00);
			av(1'b0, HREG_HEX_LO, 32'h0);
			chk(q, hv[k], "hex value");
			av(1'b0, HREG_HEX_HI, 32'h0);
			chk({28'h0, q[3:0]}, {28'h0, hl[k]}, "hex length");
		end
		$display("test hex done");
		// Four forward quadrature steps on encoder 1
		enc_a[0] <= 1'b1;
		repeat (6) @(posedge mclk);
		enc_b[0] <= 1'b1;
		repeat (6) @(posedge mclk);
		enc_a[0] <= 1'b0;
		repeat (6) @(posedge mclk);
		enc_b[0] <= 1'b0;
		repeat (6) @(posedge mclk);
		cmd(CMD_REG_TO_MBOX, 8'(SEL_CNT1), 8'h00);
		mbox_chk(32'hff862459);
		$display("test counting done");
		rdb(ADDR_SPEED1, 8'h7f, "speed1");
		rdb(ADDR_SPEED2, 8'hec, "speed2");
		spd[1] <= -16'sd300;
		rdb(ADDR_SPEED2, 8'h81, "speed2 sat");
		rdb(ADDR_SPD_DST1, 8'h7f, "spd_dst1");
		rdb(ADDR_DIST1, 8'h81, "dist1");
		rdb(ADDR_DIST2, 8'hfc, "dist2");
		wrb(ADDR_MODE, 8'h01, REPLY_OK);
		rdb(ADDR_SPD_DST2, 8'hfc, "spd_dst2");
		$display("test speed distance done");
		complete_run();
	end

	// Tests need under 1000 cycles; the 25000-cycle limit allows over twenty-five times that
	initial begin
		#100000;
		chk(32'h0, 32'h1, "watchdog");
		complete_run();
	end
endmodule : encoder_register_mailbox_tb
